// >>> core/srh_ctrl.sv
/*
 Host controller driving a 1024x4 asynchronous static memory through its pins.
 Assumes pin inputs synchronous to clock and memory data pins resolved by the bench from the enable.
 Memory data pins are resolved outside; the host drives them only while dq_oe is high.
*/
module srh_ctrl
(
	// Clock and reset
	input  wire logic                      clock,
	input  wire logic                      resetn,
	// User request
	input  wire logic                      req_valid,
	output logic                           req_ready,
	input  wire srh_pkg::srh_req_s         req,
	output logic                           rd_valid,
	output logic [srh_pkg::DATA_W-1:0]     rd_data,
	// Standby control
	input  wire logic                      standby_req,
	output logic                           in_standby,
	// Memory pins
	output srh_pkg::srh_pins_s             pins,
	input  wire logic [srh_pkg::DATA_W-1:0] dq_in,
	output logic [srh_pkg::DATA_W-1:0]     dq_out,
	output logic                           dq_oe
);
	srh_pkg::srh_state_e           state_r;
	srh_pkg::srh_state_e           state_nxt;
	logic [srh_pkg::CNT_W-1:0]     cnt_r;
	logic [srh_pkg::CNT_W-1:0]     cnt_nxt;
	logic                          cnt_done;
	logic                          access_nxt;
	logic [srh_pkg::ADDR_W-1:0]    addr_r;
	logic                          sel_low_n_r;
	logic                          sel_high_r;
	logic                          we_n_r;
	logic                          out_disable_r;
	logic                          supply_down_r;

	// Counter runs down to zero and holds
	assign cnt_done = (cnt_r == '0);
	assign req_ready = (state_r == srh_pkg::ST_IDLE) && !standby_req;
	// Chip selected in every access state
	assign access_nxt = state_nxt inside {srh_pkg::ST_WSETUP, srh_pkg::ST_WWIN, srh_pkg::ST_WREL,
		srh_pkg::ST_RWAIT};

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_done ? cnt_r : cnt_r - 8'h01;
		case (state_r)
			srh_pkg::ST_IDLE:
			begin
				if (standby_req)
				begin
					state_nxt = srh_pkg::ST_SBENTER;
					cnt_nxt = 8'(srh_pkg::STBY_SETUP_CYC - 1);
				end
				else if (req_valid)
				begin
					state_nxt = req.write ? srh_pkg::ST_WSETUP : srh_pkg::ST_RWAIT;
					cnt_nxt = req.write ? 8'h00 : 8'(srh_pkg::READ_WAIT_CYC - 1);
				end
			end
			srh_pkg::ST_WSETUP:
			begin
				state_nxt = srh_pkg::ST_WWIN;
				cnt_nxt = 8'(srh_pkg::WIN_CYC - 1);
			end
			srh_pkg::ST_WWIN:
				if (cnt_done)
				begin
					state_nxt = srh_pkg::ST_WREL;
					cnt_nxt = 8'(srh_pkg::RELEASE_CYC - 1);
				end
			srh_pkg::ST_WREL:
				if (cnt_done)
				begin
					state_nxt = srh_pkg::ST_FLOAT;
					cnt_nxt = 8'(srh_pkg::FLOAT_CYC - 1);
				end
			srh_pkg::ST_RWAIT:
				if (cnt_done)
				begin
					state_nxt = srh_pkg::ST_FLOAT;
					cnt_nxt = 8'(srh_pkg::FLOAT_CYC - 1);
				end
			srh_pkg::ST_FLOAT:
				if (cnt_done)
					state_nxt = srh_pkg::ST_IDLE;
			srh_pkg::ST_SBENTER:
				if (cnt_done)
					state_nxt = srh_pkg::ST_STANDBY;
			srh_pkg::ST_STANDBY:
				if (!standby_req)
				begin
					state_nxt = srh_pkg::ST_RECOVER;
					cnt_nxt = 8'(srh_pkg::RECOVERY_CYC - 1);
				end
			srh_pkg::ST_RECOVER:
				if (cnt_done)
					state_nxt = srh_pkg::ST_IDLE;
			default:
				state_nxt = srh_pkg::ST_IDLE;
		endcase
	end

	// State and step counter
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= srh_pkg::ST_IDLE;
			cnt_r <= 8'h00;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Latch request; address stays put until next accept
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			addr_r <= '0;
			dq_out <= '0;
		end
		else if (req_ready && req_valid)
		begin
			addr_r <= req.addr;
			dq_out <= req.wdata;
		end
	end

	// both selects active only for access
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			sel_low_n_r <= 1'h1;
			sel_high_r <= 1'h0;
		end
		else
		begin
			sel_low_n_r <= !access_nxt;
			sel_high_r <= access_nxt;
		end
	end

	// write enable low only in window
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			we_n_r <= 1'h1;
		else
			we_n_r <= (state_nxt != srh_pkg::ST_WWIN);
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			out_disable_r <= 1'h1;
		else
			out_disable_r <= (state_nxt != srh_pkg::ST_RWAIT);
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			supply_down_r <= 1'h0;
		else
			supply_down_r <= (state_nxt == srh_pkg::ST_STANDBY);
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			dq_oe <= 1'h0;
		else
			dq_oe <= state_nxt inside {srh_pkg::ST_WSETUP, srh_pkg::ST_WWIN, srh_pkg::ST_WREL};
	end

	// Pin bundle toward the memory
	assign pins = '{
		addr:                 addr_r,
		select_low_active_n:  sel_low_n_r,
		select_high_active:   sel_high_r,
		write_enable_n:       we_n_r,
		output_disable:       out_disable_r,
		standby_supply_level: supply_down_r
	};

	assign in_standby = (state_r == srh_pkg::ST_STANDBY);

	// Read data captured as the wait ends
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rd_valid <= 1'b0;
			rd_data <= '0;
		end
		else
		begin
			rd_valid <= (state_r == srh_pkg::ST_RWAIT) && cnt_done;
			if ((state_r == srh_pkg::ST_RWAIT) && cnt_done)
				rd_data <= dq_in;
		end
	end
endmodule

// >>> core/sram_host_pkg.sv
/*
 Shared constants and carriers for the static memory host controller.
 Assumes a 50 MHz system clock and one attached 1024x4 asynchronous static memory.
*/
// Behaviour
// - Host holds address through write window plus zero release time.
// - Host presents address before opening the write window.
// - Host holds data stable for the overlap time before window ends.
// - Host makes write window at least the graded minimum width.
// - Host keeps write enable high throughout every read.
// - Host deselects chip before lowering supply into standby.
// - Host keeps write enable high during every address transition.
package srh_pkg;
	localparam int CLK_PERIOD_NS = 20;
	// Slowest grade figures
	localparam int WRITE_WINDOW_WIDTH_NS = 200;
	localparam int DATA_WRITE_OVERLAP_NS = 200;
	localparam int READ_VALID_NS = 120;
	localparam int DESELECT_FLOAT_NS = 100;
	localparam int DESELECT_TO_STANDBY_NS = 0;
	localparam int STANDBY_RECOVERY_NS = 500;
	localparam int WRITE_RELEASE_NS = 0;
	// Least times round up, at least one cycle
	function automatic int min_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int WRITE_WINDOW_CYC = min_cyc(WRITE_WINDOW_WIDTH_NS);
	localparam int DATA_OVERLAP_CYC = min_cyc(DATA_WRITE_OVERLAP_NS);
	localparam int WIN_CYC = (WRITE_WINDOW_CYC > DATA_OVERLAP_CYC) ? WRITE_WINDOW_CYC : DATA_OVERLAP_CYC;
	localparam int READ_WAIT_CYC = min_cyc(READ_VALID_NS);
	localparam int FLOAT_CYC = min_cyc(DESELECT_FLOAT_NS);
	localparam int STBY_SETUP_CYC = min_cyc(DESELECT_TO_STANDBY_NS);
	localparam int RECOVERY_CYC = min_cyc(STANDBY_RECOVERY_NS);
	localparam int RELEASE_CYC = min_cyc(WRITE_RELEASE_NS);
	localparam int ADDR_W = 10;
	localparam int DATA_W = 4;
	localparam int CNT_W = 8;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} srh_req_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              select_low_active_n;
		logic              select_high_active;
		logic              write_enable_n;
		logic              output_disable;
		logic              standby_supply_level;
	} srh_pins_s;

	typedef enum logic [8:0] {
		ST_IDLE    = 9'b0_0000_0001,
		ST_WSETUP  = 9'b0_0000_0010,
		ST_WWIN    = 9'b0_0000_0100,
		ST_WREL    = 9'b0_0000_1000,
		ST_RWAIT   = 9'b0_0001_0000,
		ST_FLOAT   = 9'b0_0010_0000,
		ST_SBENTER = 9'b0_0100_0000,
		ST_STANDBY = 9'b0_1000_0000,
		ST_RECOVER = 9'b1_0000_0000
	} srh_state_e;
endpackage

// >>> verif/srh_ctrl_monitor.sv
/* Pin checker of the memory host; bound to srh_ctrl ports. */
module srh_ctrl_monitor
(
	// Clock and reset
	input wire logic               clock,
	input wire logic               resetn,
	// Memory pins
	input wire srh_pkg::srh_pins_s pins,
	input wire logic [3:0]         dq_out,
	input wire logic               dq_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	wire we_n = pins.write_enable_n;
	wire sel_n = pins.select_low_active_n;
	wire sby = pins.standby_supply_level;
	sequence s_low8; (!we_n) [*8]; endsequence
	sequence s_off8; sel_n [*8]; endsequence
	property p_win; $fell(we_n) |-> s_low8 ##1 (!we_n) [*2] ##1 we_n; endproperty
	a_win: assert property (p_win) else $error("window width");
	property p_dat; !we_n |-> $stable(dq_out) && dq_oe && !sel_n; endproperty
	a_dat: assert property (p_dat) else $error("data moved");
	property p_adr; !we_n |=> $stable(pins.addr); endproperty
	a_adr: assert property (p_adr) else $error("address moved");
	property p_first; $fell(we_n) |-> $stable(pins.addr) && !$past(sel_n); endproperty
	a_first: assert property (p_first) else $error("early window");
	property p_move; !$stable(pins.addr) |-> we_n && $past(we_n); endproperty
	a_move: assert property (p_move) else $error("address moved in write");
	property p_read; !pins.output_disable |-> we_n && !dq_oe; endproperty
	a_read: assert property (p_read) else $error("write in read");
	property p_sby; $rose(sby) |-> sel_n && $past(sel_n); endproperty
	a_sby: assert property (p_sby) else $error("standby selected");
	property p_rec; $fell(sby) |-> s_off8 ##1 s_off8 ##1 s_off8 ##1 sel_n; endproperty
	a_rec: assert property (p_rec) else $error("early access");
endmodule
bind srh_ctrl srh_ctrl_monitor u_srh_ctrl_monitor
(
	.clock  (clock),
	.resetn (resetn),
	.pins   (pins),
	.dq_out (dq_out),
	.dq_oe  (dq_oe)
);

// >>> verif/srh_mem_model.sv
/* Behavioural 1024x4 memory; resolves the data pins from both drivers. */
module srh_mem_model
(
	// Speed and memory pins
	input wire logic               slow,
	input wire srh_pkg::srh_pins_s pins,
	input wire logic [3:0]         dq_out,
	input wire logic               dq_oe,
	output logic [3:0]             dq_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] mem [1024];
	logic [3:0] q = 4'h0;
	logic       on = 1'h0;
	wire sel = !pins.select_low_active_n && pins.select_high_active;
	wire rd = sel && pins.write_enable_n && !pins.output_disable;
	always @(posedge pins.write_enable_n) if (sel) mem[pins.addr] = dq_in;
	always @(posedge rd) #20 on = 1'h1;
	always @(posedge rd) #(slow ? 100 : 50) q = mem[pins.addr];
	always @(negedge rd) #(slow ? 90 : 30) on = 1'h0;
	assign dq_in = dq_oe ? dq_out : on ? q : ~q;
endmodule

// >>> verif/test_srh_ctrl.sv
/* Bench of the memory host; a model memory answers on the pins. */
module test_srh_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'h0, resetn = 1'h0, req_valid = 1'h0, standby_req = 1'h0, slow = 1'h1;
	logic req_ready, rd_valid, in_standby, dq_oe;
	logic [3:0] rd_data, dq_in, dq_out;
	srh_pkg::srh_req_s req = '0;
	srh_pkg::srh_pins_s pins;
	int miscompares = 0, check_count = 0;
	always #10 clock = ~clock;
	srh_ctrl u_srh_ctrl
	(
		.clock       (clock),
		.resetn      (resetn),
		.req_valid   (req_valid),
		.req_ready   (req_ready),
		.req         (req),
		.rd_valid    (rd_valid),
		.rd_data     (rd_data),
		.standby_req (standby_req),
		.in_standby  (in_standby),
		.pins        (pins),
		.dq_in       (dq_in),
		.dq_out      (dq_out),
		.dq_oe       (dq_oe)
	);
	srh_mem_model u_srh_mem_model
	(
		.slow   (slow),
		.pins   (pins),
		.dq_out (dq_out),
		.dq_oe  (dq_oe),
		.dq_in  (dq_in)
	);
	task automatic cmp(input logic [3:0] got, exp);
		check_count++;
		miscompares += (got !== exp);
		if (got !== exp) $display("Error %0t %h %h", $time, got, exp);
	endtask
	task automatic op(input logic w, input logic [9:0] a, input logic [3:0] d);
		@(posedge clock);
		req_valid <= 1'h1;
		req <= '{w, a, d};
		do @(posedge clock); while (req_ready !== 1'h1);
		req_valid <= 1'h0;
		for (int n = 0; !w && rd_valid !== 1'h1 && n < 12; n++) @(posedge clock);
	endtask
	task automatic rd(input logic [9:0] a, input logic [3:0] x);
		op(1'h0, a, 4'h0);
		cmp({3'h0, rd_valid}, 4'h1);
		cmp(rd_data, x);
	endtask
	task automatic t_data;
		logic [9:0] a [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
		foreach (a[i]) op(1'h1, a[i], a[i][3:0] ^ 4'h5);
		op(1'h1, a[2], 4'hC);
		foreach (a[i]) rd(a[i], (i == 2) ? 4'hC : a[i][3:0] ^ 4'h5);
	endtask
	task automatic t_stby;
		int n;
		standby_req <= 1'h1;
		for (n = 0; in_standby !== 1'h1 && n < 9; n++) @(posedge clock);
		cmp({3'h0, in_standby}, 4'h1);
		standby_req <= 1'h0;
		slow <= 1'h0;
		for (n = 0; req_ready !== 1'h1 && n < 60; n++) @(posedge clock);
		cmp({3'h0, req_ready}, 4'h1);
		cmp(4'(n >= 500 / 20), 4'h1);
		rd(10'h2AA, 4'hF);
	endtask
	task automatic summarize;
		if (miscompares == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge clock);
		resetn <= 1'h1;
		t_data;
		t_stby;
		summarize;
	end
	initial
	begin
		#100_000 miscompares++;
		summarize;
	end
endmodule
